// file: include/clock_domains_defines.vh
`ifndef CLOCK_DOMAINS_DEFINES_VH
`define CLOCK_DOMAINS_DEFINES_VH

// fuse levels: one is unprogrammed, zero is programmed
`define FUSE_PROGRAMMED     1'b0
`define FUSE_UNPROGRAMMED   1'b1

// shipped fuse defaults
`define DEFAULT_SRC_SEL     4'h2
`define DEFAULT_STARTUP     2'h2
`define DEFAULT_DIV8        1'b0

// source select codes
`define SELCODE_RC          4'h2
`define SELCODE_EXT         4'h0
`define SELCODE_LF_LO       4'h6
`define SELCODE_LF_HI       4'h7
`define SELCODE_XTAL_LO     4'h8

// decoded source
`define SRC_XTAL            3'h0
`define SRC_LF_XTAL         3'h1
`define SRC_RC              3'h2
`define SRC_EXT             3'h3
`define SRC_RESERVED        3'h4

// start-up fuse codes
`define STARTUP_NO_DLY      2'h0
`define STARTUP_SHORT       2'h1

// sleep mode codes
`define SLP_IDLE            3'h0
`define SLP_ADC_NR          3'h1
`define SLP_PWR_DOWN        3'h2
`define SLP_PWR_SAVE        3'h3
`define SLP_STANDBY         3'h6

// reset delay in watchdog oscillator cycles
`define RST_DLY_SHORT       17'h01000
`define RST_DLY_LONG        17'h10000
// wake start-up in selected source cycles
`define WAKE_CYCLES         17'h00400

// prescale exponent
`define PRESCALE_DIV8       4'h3
`define PRESCALE_DIV1       4'h0

`define FUSE_SETTLE         2'h2

`endif

// file: hdl/clock_domains.v
// Overview of operation
// - core domain off halts core, register file, status and stack memory.
// - peripheral domain feeds timers, serial, irqs; async irq when off.
// - serial unit start detect is asynchronous with peripheral clock off.
// - program memory domain follows the core domain.
// - async timer domain keeps timer and display running in idle, ADC noise reduction and power-save sleep.
// - converter has its own domain; core and peripheral may stop meanwhile.
// - four select fuses pick crystal, low-freq crystal, RC or external clock.
// - fuse bit one means unprogrammed, zero means programmed.
// - wake from power-down/save waits start-up counted on selected source.
// - start from reset adds delay counted on watchdog oscillator.
// - reset delay is none, 4096 or 65536 watchdog oscillator cycles.
// - shipped fuses: select 0010, start-up 10, divide-by-eight programmed.
// - default runs internal RC, longest start-up, prescale eight.
// - sleep modes stop clocks of unused domains.
// - selected source feeds the generator, which fans out to all domains.
`timescale 1ns/10ps
`include "clock_domains_defines.vh"

module clock_domains #(
  parameter [16:0] RST_DLY_SHORT_CYC = `RST_DLY_SHORT,
  parameter [16:0] RST_DLY_LONG_CYC  = `RST_DLY_LONG
) (
  input  wire       mclk_i,
  input  wire       arst_n_i,
  input  wire [3:0] clock_source_select_fuses_i,
  input  wire [1:0] startup_time_fuses_i,
  input  wire       divide_by_eight_fuse_i,
  input  wire       watchdog_oscillator_i,
  input  wire       source_osc_i,
  input  wire       wake_i,
  input  wire       sleep_req_i,
  input  wire [2:0] sleep_mode_i,
  output reg        core_clock_domain_en_o,
  output reg        program_memory_clock_domain_en_o,
  output reg        peripheral_clock_domain_en_o,
  output reg        async_timer_clock_domain_en_o,
  output reg        converter_clock_domain_en_o,
  output reg        async_irq_detect_o,
  output reg        async_start_detect_o,
  output reg        core_run_o,
  output reg  [2:0] source_sel_o,
  output reg        source_reserved_o,
  output reg  [3:0] prescale_exp_o
);

  // ****************************************************************
  // states
  // ****************************************************************
  localparam [2:0] ST_LATCH = 3'h0;
  localparam [2:0] ST_RST   = 3'h1;
  localparam [2:0] ST_RUN   = 3'h2;
  localparam [2:0] ST_SLEEP = 3'h3;
  localparam [2:0] ST_WAKE  = 3'h4;

  // ****************************************************************
  // source decode
  // ****************************************************************
  function [2:0] src_of;
    input [3:0] sel;
    begin
      if (sel >= `SELCODE_XTAL_LO)
        src_of = `SRC_XTAL;
      else if (sel == `SELCODE_LF_LO || sel == `SELCODE_LF_HI)
        src_of = `SRC_LF_XTAL;
      else if (sel == `SELCODE_RC)
        src_of = `SRC_RC;
      else if (sel == `SELCODE_EXT)
        src_of = `SRC_EXT;
      else
        src_of = `SRC_RESERVED;
    end
  endfunction

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  reg  [3:0] sel_s1_q;
  reg  [3:0] sel_s2_q;
  reg  [1:0] stup_s1_q;
  reg  [1:0] stup_s2_q;
  reg        div_s1_q;
  reg        div_s2_q;
  reg        wdog_s1_q;
  reg        wdog_s2_q;
  reg        wdog_s3_q;
  reg        src_s1_q;
  reg        src_s2_q;
  reg        src_s3_q;
  reg        wake_s1_q;
  reg        wake_s2_q;

  // fuse and oscillator pins are foreign: two flops before any use
  // reset values are the shipped fuse defaults
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sel_s1_q  <= `DEFAULT_SRC_SEL;
      sel_s2_q  <= `DEFAULT_SRC_SEL;
      stup_s1_q <= `DEFAULT_STARTUP;
      stup_s2_q <= `DEFAULT_STARTUP;
      div_s1_q  <= `DEFAULT_DIV8;
      div_s2_q  <= `DEFAULT_DIV8;
      wdog_s1_q <= 1'b0;
      wdog_s2_q <= 1'b0;
      wdog_s3_q <= 1'b0;
      src_s1_q  <= 1'b0;
      src_s2_q  <= 1'b0;
      src_s3_q  <= 1'b0;
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
    end else begin
      sel_s1_q  <= clock_source_select_fuses_i;
      sel_s2_q  <= sel_s1_q;
      stup_s1_q <= startup_time_fuses_i;
      stup_s2_q <= stup_s1_q;
      div_s1_q  <= divide_by_eight_fuse_i;
      div_s2_q  <= div_s1_q;
      wdog_s1_q <= watchdog_oscillator_i;
      wdog_s2_q <= wdog_s1_q;
      wdog_s3_q <= wdog_s2_q;
      src_s1_q  <= source_osc_i;
      src_s2_q  <= src_s1_q;
      src_s3_q  <= src_s2_q;
      wake_s1_q <= wake_i;
      wake_s2_q <= wake_s1_q;
    end
  end

  // ****************************************************************
  // edge detect
  // ****************************************************************
  // third flop feeds only the rising edge detectors
  wire wdog_tick = wdog_s2_q & ~wdog_s3_q;
  wire src_tick  = src_s2_q & ~src_s3_q;

  // ****************************************************************
  // state machine
  // ****************************************************************
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [16:0] cnt_q;
  reg  [16:0] cnt_d;
  reg  [1:0]  settle_q;
  reg  [1:0]  stup_q;
  reg  [2:0]  mode_q;
  reg  [2:0]  mode_d;
  reg  [16:0] rst_len;

  // ****************************************************************
  // reset delay length
  // ****************************************************************
  // 00 none, 01 short, 10 and 11 long
  always @* begin
    case (stup_q)
      `STARTUP_NO_DLY: rst_len = 17'h00000;
      `STARTUP_SHORT:  rst_len = RST_DLY_SHORT_CYC;
      default:         rst_len = RST_DLY_LONG_CYC;
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    mode_d  = mode_q;
    case (state_q)
      ST_LATCH: begin
        cnt_d = 17'h00000;
        if (settle_q == `FUSE_SETTLE)
          state_d = ST_RST;
      end
      ST_RST: begin
        if (cnt_q >= rst_len)
          state_d = ST_RUN;
        else if (wdog_tick)
          cnt_d = cnt_q + 17'h00001;
      end
      ST_RUN: begin
        if (sleep_req_i) begin
          mode_d  = sleep_mode_i;
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        cnt_d = 17'h00000;
        if (wake_s2_q) begin
          if (mode_q == `SLP_PWR_DOWN || mode_q == `SLP_PWR_SAVE)
            state_d = ST_WAKE;
          else
            state_d = ST_RUN;
        end
      end
      ST_WAKE: begin
        if (cnt_q >= `WAKE_CYCLES)
          state_d = ST_RUN;
        else if (src_tick)
          cnt_d = cnt_q + 17'h00001;
      end
      default: begin
        state_d = ST_LATCH;
      end
    endcase
  end

  // ****************************************************************
  // domain enables
  // ****************************************************************
  // taken from the state being entered, so each enable lands with it
  reg  core_en;
  reg  per_en;
  reg  asy_en;
  reg  adc_en;
  wire asleep_d = (state_d == ST_SLEEP) | (state_d == ST_WAKE);
  always @* begin
    core_en = 1'b0;
    per_en  = 1'b0;
    asy_en  = 1'b0;
    adc_en  = 1'b0;
    case (state_d)
      ST_RUN: begin
        core_en = 1'b1;
        per_en  = 1'b1;
        asy_en  = 1'b1;
        adc_en  = 1'b1;
      end
      ST_SLEEP, ST_WAKE: begin
        case (mode_d)
          `SLP_IDLE: begin
            per_en = 1'b1;
            asy_en = 1'b1;
            adc_en = 1'b1;
          end
          `SLP_ADC_NR: begin
            asy_en = 1'b1;
            adc_en = 1'b1;
          end
          `SLP_PWR_SAVE: begin
            asy_en = 1'b1;
          end
          default: begin
            asy_en = 1'b0;
          end
        endcase
      end
      default: begin
        core_en = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // output registers
  // ****************************************************************
  // every output is a flop; enables follow the next state
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q                          <= ST_LATCH;
      cnt_q                            <= 17'h00000;
      settle_q                         <= 2'h0;
      stup_q                           <= `DEFAULT_STARTUP;
      mode_q                           <= `SLP_IDLE;
      core_clock_domain_en_o           <= 1'b0;
      program_memory_clock_domain_en_o <= 1'b0;
      peripheral_clock_domain_en_o     <= 1'b0;
      async_timer_clock_domain_en_o    <= 1'b0;
      converter_clock_domain_en_o      <= 1'b0;
      async_irq_detect_o               <= 1'b0;
      async_start_detect_o             <= 1'b0;
      core_run_o                       <= 1'b0;
      source_sel_o                     <= `SRC_RC;
      source_reserved_o                <= 1'b0;
      prescale_exp_o                   <= `PRESCALE_DIV8;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      mode_q  <= mode_d;
      if (state_q == ST_LATCH) begin
        if (settle_q != `FUSE_SETTLE)
          settle_q <= settle_q + 2'h1;
        // fuses taken in each latch cycle, the last after the synchronisers have filled;
        // later fuse changes wait for the next reset
        stup_q            <= stup_s2_q;
        source_sel_o      <= src_of(sel_s2_q);
        source_reserved_o <= (src_of(sel_s2_q) == `SRC_RESERVED);
        if (div_s2_q == `FUSE_PROGRAMMED)
          prescale_exp_o <= `PRESCALE_DIV8;
        else
          prescale_exp_o <= `PRESCALE_DIV1;
      end
      core_clock_domain_en_o           <= core_en;
      program_memory_clock_domain_en_o <= core_en;
      peripheral_clock_domain_en_o     <= per_en;
      async_timer_clock_domain_en_o    <= asy_en;
      converter_clock_domain_en_o      <= adc_en;
      // async detect holds through the wake delay until the core runs
      async_irq_detect_o   <= asleep_d & ~per_en;
      async_start_detect_o <= asleep_d & ~per_en;
      core_run_o           <= (state_d == ST_RUN);
    end
  end

endmodule // clock_domains

// file: sim/clock_domains_props.sv
`timescale 1ns/10ps
// *****
// checker
// *****
module clock_domains_props (
  input wire       mclk_i,
  input wire       arst_n_i,
  input wire [3:0] clock_source_select_fuses_i,
  input wire       divide_by_eight_fuse_i,
  input wire       sleep_req_i,
  input wire [2:0] sleep_mode_i,
  input wire       core_clock_domain_en_o,
  input wire       program_memory_clock_domain_en_o,
  input wire       peripheral_clock_domain_en_o,
  input wire       async_timer_clock_domain_en_o,
  input wire       converter_clock_domain_en_o,
  input wire       async_irq_detect_o,
  input wire       async_start_detect_o,
  input wire       core_run_o,
  input wire [2:0] source_sel_o,
  input wire       source_reserved_o,
  input wire [3:0] prescale_exp_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_req(m);
    sleep_req_i && core_run_o && sleep_mode_i == m;
  endsequence
  property p_pm;
    program_memory_clock_domain_en_o == core_clock_domain_en_o;
  endproperty
  property p_run;
    core_run_o |-> core_clock_domain_en_o;
  endproperty
  property p_idle;
    s_req(3'h0) |-> ##[1:2] !core_run_o && !core_clock_domain_en_o;
  endproperty
  property p_save;
    s_req(3'h3) |-> ##[1:2] async_timer_clock_domain_en_o
      && !peripheral_clock_domain_en_o && !core_clock_domain_en_o;
  endproperty
  property p_adc;
    s_req(3'h1) |-> ##[1:2] converter_clock_domain_en_o
      && !peripheral_clock_domain_en_o && !core_clock_domain_en_o;
  endproperty
  property p_irq;
    async_irq_detect_o |-> !peripheral_clock_domain_en_o;
  endproperty
  property p_start;
    $fell(peripheral_clock_domain_en_o) && !core_run_o |-> async_start_detect_o;
  endproperty
  property p_rsv;
    core_run_o |-> source_reserved_o == (clock_source_select_fuses_i == 4'h1
      || clock_source_select_fuses_i == 4'h3
      || clock_source_select_fuses_i[3:1] == 3'h2);
  endproperty
  property p_div;
    core_run_o |-> prescale_exp_o == (divide_by_eight_fuse_i ? 4'h0 : 4'h3);
  endproperty
  a_pm: assert property (p_pm) else $error("flash enable differs");
  a_run: assert property (p_run) else $error("run without core");
  a_idle: assert property (p_idle) else $error("idle core on");
  a_save: assert property (p_save) else $error("save enables");
  a_adc: assert property (p_adc) else $error("adc enables");
  a_irq: assert property (p_irq) else $error("irq detect");
  a_start: assert property (p_start) else $error("start detect");
  a_rsv: assert property (p_rsv) else $error("reserved flag");
  a_div: assert property (p_div) else $error("prescale");
endmodule // clock_domains_props

bind clock_domains clock_domains_props clock_domains_props_inst (
  .mclk_i(mclk_i), .arst_n_i(arst_n_i),
  .clock_source_select_fuses_i(clock_source_select_fuses_i),
  .divide_by_eight_fuse_i(divide_by_eight_fuse_i),
  .sleep_req_i(sleep_req_i), .sleep_mode_i(sleep_mode_i),
  .core_clock_domain_en_o(core_clock_domain_en_o),
  .program_memory_clock_domain_en_o(program_memory_clock_domain_en_o),
  .peripheral_clock_domain_en_o(peripheral_clock_domain_en_o),
  .async_timer_clock_domain_en_o(async_timer_clock_domain_en_o),
  .converter_clock_domain_en_o(converter_clock_domain_en_o),
  .async_irq_detect_o(async_irq_detect_o),
  .async_start_detect_o(async_start_detect_o),
  .core_run_o(core_run_o), .source_sel_o(source_sel_o),
  .source_reserved_o(source_reserved_o), .prescale_exp_o(prescale_exp_o));

// file: sim/osc_model.sv
`timescale 1ns/10ps
// *****
// free running oscillators
// *****
module osc_model (
  output reg wdog_o,
  output reg src_o
);
  initial begin
    wdog_o = 1'b0;
    src_o = 1'b0;
  end
  always #35.1 wdog_o = ~wdog_o;
  always #10.3 src_o = ~src_o;
endmodule // osc_model

// file: sim/clock_domains_test.sv
`timescale 1ns/10ps
module clock_domains_test;
  reg         mclk_i = 1'b0;
  reg         arst_n_i = 1'b0;
  reg  [3:0]  sel = 4'h2;
  reg  [1:0]  stup = 2'h2;
  reg         div8 = 1'b0;
  reg         wake = 1'b0;
  reg         req = 1'b0;
  reg  [2:0]  mode = 3'h0;
  wire [4:0]  en;
  wire        irq, sdet, run, rsv, wdog, src;
  wire [2:0]  ssel;
  wire [3:0]  pexp;
  integer     err_total = 0;
  integer     tests_run = 0;
  integer     i;
  always #5 mclk_i = ~mclk_i;
  osc_model osc_model_inst (.wdog_o(wdog), .src_o(src));
  clock_domains #(.RST_DLY_SHORT_CYC(17'h00004),
    .RST_DLY_LONG_CYC(17'h00010)) clock_domains_inst (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .clock_source_select_fuses_i(sel), .startup_time_fuses_i(stup),
    .divide_by_eight_fuse_i(div8), .watchdog_oscillator_i(wdog),
    .source_osc_i(src), .wake_i(wake), .sleep_req_i(req),
    .sleep_mode_i(mode), .core_clock_domain_en_o(en[4]),
    .program_memory_clock_domain_en_o(en[3]),
    .peripheral_clock_domain_en_o(en[2]),
    .async_timer_clock_domain_en_o(en[1]),
    .converter_clock_domain_en_o(en[0]), .async_irq_detect_o(irq),
    .async_start_detect_o(sdet), .core_run_o(run), .source_sel_o(ssel),
    .source_reserved_o(rsv), .prescale_exp_o(pexp));
  // *****
  // helpers
  // *****
  task check(input string what, input logic [4:0] seen, exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task wait_run(input integer n);
    for (i = 0; i < n && run !== 1'b1; i = i + 1) @(negedge mclk_i);
    if (run !== 1'b1) begin
      check("run timeout", run, 5'h1);
      report_and_stop;
    end
  endtask
  task do_reset(input [3:0] s, input [1:0] t, input d);
    @(posedge mclk_i);
    arst_n_i <= 1'b0;
    sel <= s;
    stup <= t;
    div8 <= d;
    repeat (6) @(posedge mclk_i);
    arst_n_i <= 1'b1;
  endtask
  function [4:0] exp_src(input [3:0] c);
    exp_src = c[3] ? 5'h0 : (c[3:1] == 3'h3) ? 5'h1 : (c == 4'h2) ? 5'h2 :
              (c == 4'h0) ? 5'h3 : 5'h4;
  endfunction
  // *****
  // scenarios
  // *****
  task t_default;
    do_reset(4'h2, 2'h2, 1'b0);
    repeat (70) @(negedge mclk_i);
    check("long delay run", run, 5'h0);
    wait_run(300);
    check("default source", ssel, 5'h2);
    check("default prescale", pexp, 5'h3);
    check("domains on", en, 5'h1f);
    $display("default start done");
  endtask
  task t_short;
    do_reset(4'h2, 2'h1, 1'b1);
    repeat (70) @(negedge mclk_i);
    check("short delay run", run, 5'h1);
    check("no prescale", pexp, 5'h0);
    $display("short start done");
  endtask
  task t_decode;
    integer c;
    for (c = 0; c < 16; c = c + 1) begin
      do_reset(c[3:0], 2'h0, 1'b0);
      wait_run(60);
      check("source", ssel, exp_src(c[3:0]));
      check("reserved", rsv, exp_src(c[3:0]) == 5'h4);
    end
    $display("decode done");
  endtask
  task t_sleep(input [2:0] m, input [4:0] exp_en, input integer dly);
    do_reset(4'h2, 2'h0, 1'b0);
    wait_run(60);
    @(posedge mclk_i);
    req <= 1'b1;
    mode <= m;
    @(posedge mclk_i);
    req <= 1'b0;
    repeat (3) @(negedge mclk_i);
    check("sleep enables", en, exp_en);
    check("async detect", irq, !exp_en[2]);
    check("start detect", sdet, !exp_en[2]);
    @(posedge mclk_i);
    wake <= 1'b1;
    repeat (dly) @(negedge mclk_i);
    check("early run", run, 5'h0);
    wait_run(2600);
    @(posedge mclk_i);
    wake <= 1'b0;
    $display("sleep mode %0d done", m);
  endtask
  initial begin
    t_default;
    t_short;
    t_decode;
    t_sleep(3'h0, 5'h07, 1);
    t_sleep(3'h1, 5'h03, 1);
    t_sleep(3'h3, 5'h02, 400);
    t_sleep(3'h2, 5'h00, 400);
    t_sleep(3'h6, 5'h00, 1);
    report_and_stop;
  end
endmodule // clock_domains_test
